// >>> src/fcr_pkg.sv
// constants, register map and field layout of the flow and character recognition block
package fcr_pkg;

  // register addresses on the host port
  localparam logic [2:0] ADDR_MATCH_OFS = 3'h0;
  localparam logic [2:0] FLOW_STATUS_OFS = 3'h1;
  localparam logic [2:0] RECOG_ENABLE_OFS = 3'h2;
  localparam logic [2:0] RESUME_CHAR_OFS = 3'h3;
  localparam logic [2:0] PAUSE_CHAR_OFS = 3'h4;

  // reset values
  localparam logic [7:0] ADDR_MATCH_RST = 8'h00;
  localparam logic [7:0] RESUME_CHAR_RST = 8'h11;
  localparam logic [7:0] PAUSE_CHAR_RST = 8'h13;

  // recognition enable register bit positions
  localparam int WD_DIS_BIT = 7;
  localparam int WD_EN_BIT = 6;
  localparam int AR_DIS_BIT = 5;
  localparam int AR_EN_BIT = 4;
  localparam int XON_DIS_BIT = 3;
  localparam int XON_EN_BIT = 2;
  localparam int XOFF_DIS_BIT = 1;
  localparam int XOFF_EN_BIT = 0;

  // watchdog idle bit times
  localparam int WDOG_IDLE_BITS = 64;

  // transmitter flow field states
  typedef enum logic [1:0] {
    FLOW_NORMAL = 2'h0,
    FLOW_PENDING = 2'h1,
    FLOW_REENABLED = 2'h2,
    FLOW_HALTED = 2'h3
  } fcr_flow_e;

  // transmitted character status
  typedef enum logic [1:0] {
    TXC_NORMAL = 2'h0,
    TXC_WAIT_DATA = 2'h1,
    TXC_XOFF_PEND = 2'h2,
    TXC_XON_PEND = 2'h3
  } fcr_txc_e;

  // resolve one enable/disable pair of the recognition enable register
  function automatic logic pair_next(input logic cur, input logic dis, input logic en);
    logic r;
    r = cur;
    if (dis) begin
      r = 1'b0;
    end else if (en) begin
      r = 1'b1;
    end
    return r;
  endfunction

endpackage

// >>> src/fcr_match_if.sv
// carrier between the character comparator and the control logic
`timescale 1ns/1ns
interface fcr_match_if;
  logic rx_valid;
  logic [7:0] rx_char;
  logic [7:0] addr_val;
  logic [7:0] xon_val;
  logic [7:0] xoff_val;
  logic addr_hit;
  logic xon_hit;
  logic xoff_hit;

  modport cmp (
    input rx_valid,
    input rx_char,
    input addr_val,
    input xon_val,
    input xoff_val,
    output addr_hit,
    output xon_hit,
    output xoff_hit
  );

  modport ctl (
    output rx_valid,
    output rx_char,
    output addr_val,
    output xon_val,
    output xoff_val,
    input addr_hit,
    input xon_hit,
    input xoff_hit
  );
endinterface

// >>> src/fcr_compare.sv
// registered compare of each received character against the three match values
`timescale 1ns/1ns
module fcr_compare (
  input wire logic core_clk,
  input wire logic rst_n,
  fcr_match_if.cmp m
);

  // one-cycle hit pulses, independent of any mode bit
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      m.addr_hit <= 1'b0;
      m.xon_hit <= 1'b0;
      m.xoff_hit <= 1'b0;
    end else begin
      m.addr_hit <= m.rx_valid && (m.rx_char == m.addr_val);
      m.xon_hit <= m.rx_valid && (m.rx_char == m.xon_val);
      m.xoff_hit <= m.rx_valid && (m.rx_char == m.xoff_val);
    end
  end

endmodule

// >>> src/fcr_watchdog.sv
// receiver watchdog: one event after a run of idle bit times
`timescale 1ns/1ns
module fcr_watchdog #(
  parameter int IDLE_BITS = fcr_pkg::WDOG_IDLE_BITS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic rx_bit_tick,
  input wire logic rx_idle,
  output logic fire
);

  localparam int CW = $clog2(IDLE_BITS + 1);
  localparam logic [CW-1:0] LIMIT = CW'(IDLE_BITS);

  logic [CW-1:0] idle_cnt;

  // count idle bit times; fire once, then wait for line activity
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      idle_cnt <= '0;
      fire <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (!enable || !rx_idle) begin
        idle_cnt <= '0;
      end else if (rx_bit_tick && idle_cnt != LIMIT) begin
        idle_cnt <= idle_cnt + 1'b1;
        fire <= (idle_cnt == LIMIT - 1'b1);
      end
    end
  end

endmodule

// >>> src/fcr_flow_char_recog.sv
// per-channel flow control status and character recognition
`timescale 1ns/1ns
module fcr_flow_char_recog #(
  parameter int IDLE_BITS = fcr_pkg::WDOG_IDLE_BITS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  // host register port
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // mode register bits held elsewhere
  input wire logic mode_reg_zero_wr,
  input wire logic mode_reg_zero_wdog,
  input wire logic auto_rx_flow,
  input wire logic auto_tx_flow,
  input wire logic [1:0] mode_reg_three_xctl,
  // receiver side
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_bit_tick,
  input wire logic rx_idle,
  // transmitter side
  input wire logic tx_bit_tick,
  input wire logic tx_busy,
  input wire logic tx_char_done,
  input wire logic tx_sent_xon,
  input wire logic tx_sent_xoff,
  input wire logic tx_queue_empty,
  input wire logic cmd_send_xon,
  input wire logic cmd_send_xoff,
  output logic tx_hold,
  output logic send_xon_req,
  output logic send_xoff_req,
  // reports toward the interrupt status register
  output logic ev_addr_match,
  output logic ev_xon_match,
  output logic ev_xoff_match,
  output logic ev_watchdog,
  output logic wdog_enable
);

  // character registers seen by the comparator
  logic [7:0] address_match_char;
  logic [7:0] resume_char_reg;
  logic [7:0] pause_char_reg;

  // recognition enables, set and cleared through the enable register
  logic addr_recog_en;
  logic xon_recog_en;
  logic xoff_recog_en;

  // status fields; these two are cleared by a status read
  logic [1:0] rx_flow_seen;
  logic [1:0] auto_sent;

  // transmitter flow and character status states
  fcr_pkg::fcr_flow_e flow_state;
  fcr_pkg::fcr_flow_e next_flow_state;
  fcr_pkg::fcr_txc_e txc_state;
  fcr_pkg::fcr_txc_e next_txc_state;

  // internal strobes
  logic wd_fire;
  logic status_rd;
  logic enable_wr;

  // carrier toward the comparator
  fcr_match_if mif ();

  // register access strobes decoded from the host port
  assign status_rd = reg_rd && (reg_addr == fcr_pkg::FLOW_STATUS_OFS);
  assign enable_wr = reg_wr && (reg_addr == fcr_pkg::RECOG_ENABLE_OFS);

  // comparator inputs
  assign mif.rx_valid = rx_char_valid;
  assign mif.rx_char = rx_char;
  assign mif.addr_val = address_match_char;
  assign mif.xon_val = resume_char_reg;
  assign mif.xoff_val = pause_char_reg;

  // registered compare, hits arrive one cycle behind the character
  fcr_compare u_compare (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .m(mif.cmp)
  );

  // receiver idle watchdog, one event per idle run
  fcr_watchdog #(
    .IDLE_BITS(IDLE_BITS)
  ) u_watchdog (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(wdog_enable),
    .rx_bit_tick(rx_bit_tick),
    .rx_idle(rx_idle),
    .fire(wd_fire)
  );

  // host writable character registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      address_match_char <= fcr_pkg::ADDR_MATCH_RST;
      resume_char_reg <= fcr_pkg::RESUME_CHAR_RST;
      pause_char_reg <= fcr_pkg::PAUSE_CHAR_RST;
    end else if (reg_wr) begin
      if (reg_addr == fcr_pkg::ADDR_MATCH_OFS) begin
        address_match_char <= reg_wdata;
      end
      if (reg_addr == fcr_pkg::RESUME_CHAR_OFS) begin
        resume_char_reg <= reg_wdata;
      end
      if (reg_addr == fcr_pkg::PAUSE_CHAR_OFS) begin
        pause_char_reg <= reg_wdata;
      end
    end
  end

  // recognition enables; the disable bit wins over the enable bit
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      addr_recog_en <= 1'b0;
      xon_recog_en <= 1'b0;
      xoff_recog_en <= 1'b0;
    end else if (enable_wr) begin
      addr_recog_en <= fcr_pkg::pair_next(addr_recog_en, reg_wdata[fcr_pkg::AR_DIS_BIT],
                                          reg_wdata[fcr_pkg::AR_EN_BIT]);
      xon_recog_en <= fcr_pkg::pair_next(xon_recog_en, reg_wdata[fcr_pkg::XON_DIS_BIT],
                                         reg_wdata[fcr_pkg::XON_EN_BIT]);
      xoff_recog_en <= fcr_pkg::pair_next(xoff_recog_en, reg_wdata[fcr_pkg::XOFF_DIS_BIT],
                                          reg_wdata[fcr_pkg::XOFF_EN_BIT]);
    end
  end

  // watchdog enable, shared by the mode register and the enable register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wdog_enable <= 1'b0;
    end else if (enable_wr) begin
      wdog_enable <= fcr_pkg::pair_next(wdog_enable, reg_wdata[fcr_pkg::WD_DIS_BIT],
                                        reg_wdata[fcr_pkg::WD_EN_BIT]);
    end else if (mode_reg_zero_wr) begin
      wdog_enable <= mode_reg_zero_wdog;
    end
  end

  // match and watchdog reports only; nothing here steers flow or wake-up
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ev_addr_match <= 1'b0;
      ev_xon_match <= 1'b0;
      ev_xoff_match <= 1'b0;
      ev_watchdog <= 1'b0;
    end else begin
      ev_addr_match <= mif.addr_hit && addr_recog_en;
      ev_xon_match <= mif.xon_hit && xon_recog_en;
      ev_xoff_match <= mif.xoff_hit && xoff_recog_en;
      ev_watchdog <= wd_fire;
    end
  end

  // received flow characters: sticky, cleared by status read, a new hit wins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_flow_seen <= 2'h0;
    end else begin
      rx_flow_seen[0] <= (rx_flow_seen[0] && !status_rd) || mif.xoff_hit;
      rx_flow_seen[1] <= (rx_flow_seen[1] && !status_rd) || mif.xon_hit;
    end
  end

  // automatic flow characters sent while auto receive mode is on
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      auto_sent <= 2'h0;
    end else if (!auto_rx_flow) begin
      auto_sent <= 2'h0;
    end else begin
      auto_sent[0] <= (auto_sent[0] && !status_rd) || tx_sent_xon;
      auto_sent[1] <= (auto_sent[1] && !status_rd) || tx_sent_xoff;
    end
  end

  // transmitter flow field driven by received xon and xoff
  always_comb begin
    next_flow_state = flow_state;
    unique case (flow_state)
      fcr_pkg::FLOW_NORMAL: begin
        if (mif.xoff_hit) begin
          next_flow_state = tx_busy ? fcr_pkg::FLOW_PENDING : fcr_pkg::FLOW_HALTED;
        end
      end
      fcr_pkg::FLOW_PENDING: begin
        if (mif.xon_hit) begin
          next_flow_state = fcr_pkg::FLOW_NORMAL;
        end else if (tx_char_done || !tx_busy) begin
          next_flow_state = fcr_pkg::FLOW_HALTED;
        end
      end
      fcr_pkg::FLOW_HALTED: begin
        if (mif.xon_hit) begin
          next_flow_state = fcr_pkg::FLOW_REENABLED;
        end
      end
      fcr_pkg::FLOW_REENABLED: begin
        if (mif.xoff_hit) begin
          next_flow_state = tx_busy ? fcr_pkg::FLOW_PENDING : fcr_pkg::FLOW_HALTED;
        end else if (status_rd) begin
          next_flow_state = fcr_pkg::FLOW_NORMAL;
        end
      end
    endcase
  end

  // flow field register; normal whenever automatic transmit flow is off
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flow_state <= fcr_pkg::FLOW_NORMAL;
    end else if (!auto_tx_flow) begin
      flow_state <= fcr_pkg::FLOW_NORMAL;
    end else begin
      flow_state <= next_flow_state;
    end
  end

  // transmitted character status sequence
  always_comb begin
    next_txc_state = txc_state;
    unique case (txc_state)
      fcr_pkg::TXC_NORMAL: begin
        if (cmd_send_xon) begin
          next_txc_state = fcr_pkg::TXC_XON_PEND;
        end else if (cmd_send_xoff) begin
          next_txc_state = fcr_pkg::TXC_XOFF_PEND;
        end
      end
      fcr_pkg::TXC_XOFF_PEND: begin
        if (tx_sent_xoff) begin
          next_txc_state = fcr_pkg::TXC_WAIT_DATA;
        end
      end
      fcr_pkg::TXC_XON_PEND: begin
        if (tx_sent_xon) begin
          next_txc_state = fcr_pkg::TXC_WAIT_DATA;
        end
      end
      fcr_pkg::TXC_WAIT_DATA: begin
        if (cmd_send_xon) begin
          next_txc_state = fcr_pkg::TXC_XON_PEND;
        end else if (cmd_send_xoff) begin
          next_txc_state = fcr_pkg::TXC_XOFF_PEND;
        end else if (tx_bit_tick && !tx_queue_empty) begin
          next_txc_state = fcr_pkg::TXC_NORMAL;
        end
      end
    endcase
  end

  // character status register; zero while no transmit flow control is on
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      txc_state <= fcr_pkg::TXC_NORMAL;
    end else if (mode_reg_three_xctl == 2'h0) begin
      txc_state <= fcr_pkg::TXC_NORMAL;
    end else begin
      txc_state <= next_txc_state;
    end
  end

  // transmitter controls from the two fields
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_hold <= 1'b0;
      send_xon_req <= 1'b0;
      send_xoff_req <= 1'b0;
    end else begin
      tx_hold <= auto_tx_flow && (next_flow_state == fcr_pkg::FLOW_PENDING ||
                                  next_flow_state == fcr_pkg::FLOW_HALTED);
      send_xon_req <= (mode_reg_three_xctl != 2'h0) &&
                      (next_txc_state == fcr_pkg::TXC_XON_PEND);
      send_xoff_req <= (mode_reg_three_xctl != 2'h0) &&
                       (next_txc_state == fcr_pkg::TXC_XOFF_PEND);
    end
  end

  // registered read data; the enable register is write only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        fcr_pkg::ADDR_MATCH_OFS: reg_rdata <= address_match_char;
        fcr_pkg::FLOW_STATUS_OFS: begin
          reg_rdata <= {rx_flow_seen, auto_sent, flow_state, txc_state};
        end
        fcr_pkg::RESUME_CHAR_OFS: reg_rdata <= resume_char_reg;
        fcr_pkg::PAUSE_CHAR_OFS: reg_rdata <= pause_char_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// >>> bench/fcr_properties.sv
// concurrent checks on the ports of the flow and character recognition block
`timescale 1ns/1ns
module fcr_properties #(
  parameter int IDLE_BITS = fcr_pkg::WDOG_IDLE_BITS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic mode_reg_zero_wr,
  input wire logic mode_reg_zero_wdog,
  input wire logic auto_tx_flow,
  input wire logic [1:0] mode_reg_three_xctl,
  input wire logic rx_char_valid,
  input wire logic cmd_send_xon,
  input wire logic cmd_send_xoff,
  input wire logic tx_sent_xoff,
  input wire logic tx_hold,
  input wire logic send_xon_req,
  input wire logic send_xoff_req,
  input wire logic ev_addr_match,
  input wire logic ev_xon_match,
  input wire logic ev_xoff_match,
  input wire logic wdog_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // write to the recognition enable register
  logic ew;
  assign ew = reg_wr && (reg_addr == fcr_pkg::RECOG_ENABLE_OFS);
  // steps of one xoff transfer
  sequence s_cmd_off;
    cmd_send_xoff && !cmd_send_xon && (mode_reg_three_xctl != 2'h0);
  endsequence
  sequence s_sent_off;
    send_xoff_req && tx_sent_xoff;
  endsequence
  xoff_req_set_a: assert property (s_cmd_off |=> send_xoff_req)
    else $error("xoff request not raised");
  xoff_req_clr_a: assert property (s_sent_off |=> !send_xoff_req)
    else $error("xoff request not cleared");
  xon_req_cause_a: assert property ($rose(send_xon_req) |-> $past(cmd_send_xon))
    else $error("xon request without command");
  txc_off_a: assert property ((mode_reg_three_xctl == 2'h0) |=> !send_xoff_req)
    else $error("request while transmit control off");
  ev_addr_a: assert property (ev_addr_match |-> $past(rx_char_valid, 2))
    else $error("address report without character");
  ev_xon_a: assert property (ev_xon_match |-> $past(rx_char_valid, 2))
    else $error("xon report without character");
  ev_xoff_a: assert property (ev_xoff_match |-> $past(rx_char_valid, 2))
    else $error("xoff report without character");
  hold_free_a: assert property ((!auto_tx_flow) [*2] |-> !tx_hold)
    else $error("hold without transmit flow mode");
  wd_on_a: assert property (ew && reg_wdata[6] && !reg_wdata[7] |=> wdog_enable)
    else $error("watchdog not enabled");
  wd_both_a: assert property (ew && reg_wdata[7] |=> !wdog_enable)
    else $error("watchdog not disabled");
  wd_mode_a: assert property (mode_reg_zero_wr && !ew |=>
    wdog_enable == $past(mode_reg_zero_wdog))
    else $error("watchdog enable not shared with mode register");
endmodule

// >>> bench/fcr_remote_node.sv
// remote serial node: sends characters to the receiver, line idle otherwise
`timescale 1ns/1ns
module fcr_remote_node (
  input wire logic core_clk,
  output logic rx_char_valid,
  output logic [7:0] rx_char,
  output logic rx_bit_tick,
  output logic rx_idle
);
  initial begin
    rx_char_valid = 1'b0;
    rx_char = 8'h00;
    rx_bit_tick = 1'b0;
    rx_idle = 1'b1;
  end
  // line bit clock, one tick every two core cycles
  always @(posedge core_clk) begin
    rx_bit_tick <= ~rx_bit_tick;
  end
  // one character after an optional gap; data shows its inverse once released
  task automatic send(input logic [7:0] c, input int gap);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    rx_idle <= 1'b0;
    rx_char_valid <= 1'b1;
    rx_char <= c;
    @(posedge core_clk);
    rx_char_valid <= 1'b0;
    rx_char <= ~c;
    rx_idle <= 1'b1;
  endtask
endmodule

// >>> bench/tb_top.sv
// self-checking bench of the flow and character recognition block
`timescale 1ns/1ns
module tb_top;
  localparam int IDLE_BITS = 4;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic mr0_wr = 1'b0;
  logic mr0_wdog = 1'b0;
  logic auto_rx = 1'b0;
  logic auto_tx = 1'b0;
  logic [1:0] xctl = 2'h0;
  logic tx_busy = 1'b0;
  logic q_empty = 1'b1;
  logic [5:0] txp = 6'h00; // tick, done, sent xon, sent xoff, cmd xon, cmd xoff
  logic [7:0] reg_rdata;
  logic [7:0] rx_c;
  logic rx_v, rx_bt, rx_idle, tx_hold, rq_on, rq_off, ev_a, ev_on, ev_off, ev_wd, wd_en;
  int mismatches = 0;
  int checks_done = 0;
  int ev_n [4] = '{0, 0, 0, 0};
  int i;

  fcr_flow_char_recog #(.IDLE_BITS(IDLE_BITS)) u_fcr_flow_char_recog (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .mode_reg_zero_wr(mr0_wr), .mode_reg_zero_wdog(mr0_wdog), .auto_rx_flow(auto_rx),
    .auto_tx_flow(auto_tx), .mode_reg_three_xctl(xctl), .rx_char_valid(rx_v),
    .rx_char(rx_c), .rx_bit_tick(rx_bt), .rx_idle(rx_idle), .tx_bit_tick(txp[5]),
    .tx_busy(tx_busy), .tx_char_done(txp[4]), .tx_sent_xon(txp[3]),
    .tx_sent_xoff(txp[2]), .tx_queue_empty(q_empty), .cmd_send_xon(txp[1]),
    .cmd_send_xoff(txp[0]), .tx_hold(tx_hold), .send_xon_req(rq_on),
    .send_xoff_req(rq_off), .ev_addr_match(ev_a), .ev_xon_match(ev_on),
    .ev_xoff_match(ev_off), .ev_watchdog(ev_wd), .wdog_enable(wd_en));
  fcr_remote_node u_fcr_remote_node (.core_clk(core_clk), .rx_char_valid(rx_v),
    .rx_char(rx_c), .rx_bit_tick(rx_bt), .rx_idle(rx_idle));

  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // count report pulses
  always @(posedge core_clk) begin
    if (ev_a === 1'b1) ev_n[0]++;
    if (ev_on === 1'b1) ev_n[1]++;
    if (ev_off === 1'b1) ev_n[2]++;
    if (ev_wd === 1'b1) ev_n[3]++;
  end

  task final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task w(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1; // let the written register settle before a compare reads it
  endtask
  task rd(input string n, input logic [2:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(n, e, reg_rdata);
  endtask
  task tp(input logic [5:0] v);
    @(posedge core_clk);
    txp <= v;
    @(posedge core_clk);
    txp <= 6'h00;
    w(2);
  endtask
  task xs(input logic on);
    tp(on ? 6'h02 : 6'h01);
    tp(on ? 6'h08 : 6'h04);
    tp(6'h20);
  endtask
  task mr0(input logic v);
    @(posedge core_clk);
    mr0_wr <= 1'b1;
    mr0_wdog <= v;
    @(posedge core_clk);
    mr0_wr <= 1'b0;
    w(1);
  endtask
  task rx(input logic [7:0] c);
    u_fcr_remote_node.send(c, 2);
    w(3);
  endtask

  initial begin
    w(20000);
    mismatches++;
    final_report;
  end

  initial begin
    w(2);
    rst_n <= 1'b1;
    rd("addr_match", 3'h0, 8'h00);
    rd("resume_char", 3'h3, 8'h11);
    rd("pause_char", 3'h4, 8'h13);
    rd("status", 3'h1, 8'h00);
    chk("wdog_enable", 8'h00, {7'h00, wd_en});
    wr(3'h0, 8'h5a);
    rd("addr_match", 3'h0, 8'h5a);
    wr(3'h1, 8'hff);
    rd("status", 3'h1, 8'h00);
    $display("test registers done");
    rx(8'h13);
    rd("status", 3'h1, 8'h40);
    rd("status", 3'h1, 8'h00);
    rx(8'h11);
    rx(8'h13);
    rx(8'h42);
    rd("status", 3'h1, 8'hc0);
    rx(8'h11);
    rd("status", 3'h1, 8'h80);
    chk("ev_xoff_count", 8'h00, 8'(ev_n[2]));
    $display("test received field done");
    wr(3'h2, 8'h15);
    rx(8'h5a);
    rx(8'h11);
    rx(8'h13);
    chk("ev_addr_count", 8'h01, 8'(ev_n[0]));
    chk("ev_xon_count", 8'h01, 8'(ev_n[1]));
    chk("tx_hold", 8'h00, {7'h00, tx_hold});
    wr(3'h2, 8'h0b);
    rx(8'h11);
    rx(8'h13);
    chk("ev_xon_count", 8'h01, 8'(ev_n[1]));
    chk("ev_xoff_count", 8'h01, 8'(ev_n[2]));
    rd("status", 3'h1, 8'hc0);
    wr(3'h2, 8'h40);
    chk("wdog_enable", 8'h01, {7'h00, wd_en});
    mr0(1'b0);
    chk("wdog_enable", 8'h00, {7'h00, wd_en});
    mr0(1'b1);
    chk("wdog_enable", 8'h01, {7'h00, wd_en});
    wr(3'h2, 8'hc0);
    chk("wdog_enable", 8'h00, {7'h00, wd_en});
    wr(3'h2, 8'h40);
    for (i = 0; i < 60 && ev_n[3] == 0; i++) w(1);
    w(20);
    chk("ev_watchdog_count", 8'h01, 8'(ev_n[3]));
    wr(3'h2, 8'h80);
    $display("test recognition enable done");
    @(posedge core_clk);
    auto_tx <= 1'b1;
    tx_busy <= 1'b1;
    rx(8'h13);
    rd("status", 3'h1, 8'h44);
    chk("tx_hold", 8'h01, {7'h00, tx_hold});
    tp(6'h10);
    rd("status", 3'h1, 8'h0c);
    rx(8'h11);
    rd("status", 3'h1, 8'h88);
    chk("tx_hold", 8'h00, {7'h00, tx_hold});
    rd("status", 3'h1, 8'h00);
    @(posedge core_clk);
    auto_tx <= 1'b0;
    tx_busy <= 1'b0;
    $display("test flow field done");
    tp(6'h01);
    chk("send_xoff_req", 8'h00, {7'h00, rq_off});
    rd("status", 3'h1, 8'h00);
    @(posedge core_clk);
    xctl <= 2'h3;
    auto_rx <= 1'b1;
    tp(6'h02);
    chk("send_xon_req", 8'h01, {7'h00, rq_on});
    rd("status", 3'h1, 8'h03);
    tp(6'h08);
    tp(6'h20);
    rd("status", 3'h1, 8'h11);
    @(posedge core_clk);
    q_empty <= 1'b0;
    tp(6'h20);
    rd("status", 3'h1, 8'h00);
    xs(1'b0);
    xs(1'b1);
    rd("status", 3'h1, 8'h30);
    xs(1'b0);
    @(posedge core_clk);
    auto_rx <= 1'b0;
    tp(6'h02);
    rd("status", 3'h1, 8'h03);
    $display("test transmit status done");
    final_report;
  end
endmodule

bind fcr_flow_char_recog fcr_properties #(.IDLE_BITS(IDLE_BITS)) u_fcr_properties (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .mode_reg_zero_wr(mode_reg_zero_wr),
  .mode_reg_zero_wdog(mode_reg_zero_wdog), .auto_tx_flow(auto_tx_flow),
  .mode_reg_three_xctl(mode_reg_three_xctl), .rx_char_valid(rx_char_valid),
  .cmd_send_xon(cmd_send_xon), .cmd_send_xoff(cmd_send_xoff),
  .tx_sent_xoff(tx_sent_xoff), .tx_hold(tx_hold), .send_xon_req(send_xon_req),
  .send_xoff_req(send_xoff_req), .ev_addr_match(ev_addr_match),
  .ev_xon_match(ev_xon_match), .ev_xoff_match(ev_xoff_match),
  .wdog_enable(wdog_enable));
